//--- core/hcer_regs.sv
// Local design decision: the strobed register port.
`timescale 1ns/1ps
// Functional notes
// RL1: After reset with prom present, load station address starting at word 0x1.
// RL2: Word 0x1 to low, 0x2 to middle, 0x3 to high register.
// RL3: Address registers are host read/write; writes never reach the prom.
// RL4: Without prom, software writes the station address itself.
// RL5: Data pin high at reset means prom present; only then load.
// RL6: Bus control bit 2 selects clock source; 0 is 125 MHz.
// RL7: Bus control bits 1-0 select divide by one, two, three; 11 reserved.
// RL8: Bus control bit 6 selects 8 mA or 16 mA drive; resets 0.
// RL9: Software keeps the undivided bus clock unless the host runs faster.
// RL10: Prom control bit 4 hands prom pins to software; resets 0.
// RL11: Write-only bit 5 selects software read or write direction.
// RL12: Read-only bit 3 returns the live prom data pin level.
// RL13: Bits 2, 1, 0 drive data-out, serial clock, chip select.
// RL14: Software alone times prom accesses while software access is on.
// RL15: Loader owns prom pins during the fetch, releases them when done.
// RL16: Self test of both packet memories runs after every reset.
// RL17: TX test: bit 12 done, bit 11 failed, bits 10-8 fail count.
// RL18: RX test: bit 4 done, bit 3 failed, bits 2-0 count; rest zero.
// RL19: Prom presence captured at reset into config bit 9.
module hcer_regs
    import hcer_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    output logic irq_o,
    // Memory self test results
    input wire logic tx_selftest_failed_i,
    input wire logic [2:0] tx_selftest_fail_count_i,
    input wire logic rx_selftest_failed_i,
    input wire logic [2:0] rx_selftest_fail_count_i,
    // Prom pins
    input wire logic prom_data_pin_i,
    output logic prom_data_pin_o,
    output logic prom_data_pin_oe_o,
    output logic prom_serial_clock_pin_o,
    output logic prom_chip_select_pin_o,
    // Chip settings
    output logic drive_16ma_o,
    output logic [1:0] bus_clk_div_o
);

    hcer_state_t s_ff;
    hcer_state_t nxt_s;
    hcer_bus_req_t req;
    logic ld_busy;
    logic sw_on;
    logic [15:0] prom_ctl_rd;
    logic [15:0] bist_rd;
    logic load_evt;
    logic bist_evt;

    assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};
    assign ld_busy = (s_ff.ld != LD_IDLE) && (s_ff.ld != LD_DONE);
    assign sw_on = s_ff.prom_ctl[PCT_EN_BIT] && !ld_busy;
    assign prom_ctl_rd = {10'h000, 1'b0, s_ff.prom_ctl[PCT_EN_BIT], s_ff.din_s2,
        s_ff.prom_ctl[PCT_DO_BIT:0]}; // RL11 RL12
    assign bist_rd = {3'h0, s_ff.bist[12:8], 3'h0, s_ff.bist[4:0]}; // RL18
    assign load_evt = (s_ff.ld == LD_STORE) && (s_ff.word_idx == 2'd2);
    assign bist_evt = (s_ff.bist_cnt == 7'(BIST_CYCLES - 1));

    //----------------------------------------
    // Next state
    //----------------------------------------
    always_comb begin
        nxt_s = s_ff;
        nxt_s.din_s1 = prom_data_pin_i;
        nxt_s.din_s2 = s_ff.din_s1;
        nxt_s.rdata = RESET_ZERO16;
        // Presence strap caught once the pin synchroniser has filled
        if (!s_ff.strap_taken && s_ff.bit_cnt == STRAP_WAIT) begin
            nxt_s.strap_taken = 1'b1;
            nxt_s.present = s_ff.din_s2; // RL5 RL19
            if (s_ff.din_s2) begin
                nxt_s.ld = LD_CSUP; // RL1
            end else begin
                nxt_s.ld = LD_DONE;
            end
        end
        // Self test sequencer
        if (!s_ff.bist[12]) begin
            nxt_s.bist_cnt = s_ff.bist_cnt + 7'd1;
            if (bist_evt) begin
                nxt_s.bist[12] = 1'b1; // RL16 RL17
                nxt_s.bist[11] = tx_selftest_failed_i; // RL17
                nxt_s.bist[10:8] = tx_selftest_fail_count_i; // RL17
                nxt_s.bist[4] = 1'b1; // RL18
                nxt_s.bist[3] = rx_selftest_failed_i; // RL18
                nxt_s.bist[2:0] = rx_selftest_fail_count_i; // RL18
            end
        end
        // Loader sequencer: read op, 8-bit address, 16 data bits
        nxt_s.half_cnt = s_ff.half_cnt + 8'd1;
        unique case (s_ff.ld)
            LD_IDLE: begin
                nxt_s.half_cnt = 8'd0;
                nxt_s.bit_cnt = s_ff.bit_cnt + 5'd1;
            end
            LD_CSUP: begin
                nxt_s.shreg = {PROM_READ_OP, PROM_FIRST_WORD + 8'(s_ff.word_idx), 16'h0000};
                nxt_s.bit_cnt = 5'd0;
                nxt_s.sk_ph = 1'b0;
                nxt_s.half_cnt = 8'd0;
                nxt_s.ld = LD_SHIFT;
            end
            LD_SHIFT: begin
                if (s_ff.half_cnt == 8'(PROM_SK_HALF_CYC - 1)) begin
                    nxt_s.half_cnt = 8'd0;
                    nxt_s.sk_ph = !s_ff.sk_ph;
                    if (s_ff.sk_ph) begin
                        nxt_s.shreg = {s_ff.shreg[25:0], s_ff.din_s2};
                        nxt_s.bit_cnt = s_ff.bit_cnt + 5'd1;
                        if (s_ff.bit_cnt == SHIFT_LAST) begin
                            nxt_s.ld = LD_STORE;
                        end
                    end
                end
            end
            LD_STORE: begin
                unique case (s_ff.word_idx)
                    2'd0: nxt_s.mac_low = s_ff.shreg[15:0]; // RL2
                    2'd1: nxt_s.mac_mid = s_ff.shreg[15:0]; // RL2
                    default: nxt_s.mac_high = s_ff.shreg[15:0]; // RL2
                endcase
                if (s_ff.word_idx == 2'd2) begin
                    nxt_s.ld = LD_DONE;
                end else begin
                    nxt_s.word_idx = s_ff.word_idx + 2'd1;
                    nxt_s.ld = LD_CSUP;
                end
            end
            LD_DONE: begin
                nxt_s.half_cnt = 8'd0;
            end
            default: nxt_s.ld = LD_DONE;
        endcase
        // Register writes
        if (req.wr) begin
            unique case (req.addr)
                ADDR_MAC_LOW: nxt_s.mac_low = req.wdata; // RL3
                ADDR_MAC_MID: nxt_s.mac_mid = req.wdata; // RL3
                ADDR_MAC_HIGH: nxt_s.mac_high = req.wdata; // RL3
                ADDR_BUS_CLK: nxt_s.bus_clk = req.wdata & BCC_WR_MASK; // RL6 RL7 RL8
                ADDR_PROM_CTL: nxt_s.prom_ctl = req.wdata[5:0]; // RL10 RL11 RL13
                ADDR_IRQ_STAT: nxt_s.irq_stat = s_ff.irq_stat & ~req.wdata[1:0];
                ADDR_IRQ_MASK: nxt_s.irq_mask = req.wdata[1:0];
                default: ;
            endcase
        end
        // Events win over a clear
        if (load_evt) begin
            nxt_s.irq_stat[IRQ_LOAD_BIT] = 1'b1;
        end
        if (bist_evt && !s_ff.bist[12]) begin
            nxt_s.irq_stat[IRQ_BIST_BIT] = 1'b1;
        end
        // Register reads
        if (req.rd) begin
            unique case (req.addr)
                ADDR_CHIP_CFG: nxt_s.rdata = 16'(s_ff.present) << CCR_PRESENT_BIT; // RL19
                ADDR_MAC_LOW: nxt_s.rdata = s_ff.mac_low;
                ADDR_MAC_MID: nxt_s.rdata = s_ff.mac_mid;
                ADDR_MAC_HIGH: nxt_s.rdata = s_ff.mac_high;
                ADDR_BUS_CLK: nxt_s.rdata = s_ff.bus_clk;
                ADDR_PROM_CTL: nxt_s.rdata = prom_ctl_rd;
                ADDR_BIST: nxt_s.rdata = bist_rd;
                ADDR_IRQ_STAT: nxt_s.rdata = {14'h0000, s_ff.irq_stat};
                ADDR_IRQ_MASK: nxt_s.rdata = {14'h0000, s_ff.irq_mask};
                default: nxt_s.rdata = RESET_ZERO16;
            endcase
        end
        // Pin ownership
        if (ld_busy) begin
            nxt_s.pins.cs = (s_ff.ld == LD_SHIFT); // RL15
            nxt_s.pins.sk = s_ff.sk_ph && (s_ff.ld == LD_SHIFT); // RL15
            nxt_s.pins.do_o = s_ff.shreg[26]; // RL15
            // Let go of the data pin just after the last address bit is clocked in
            nxt_s.pins.do_oe = (s_ff.ld == LD_SHIFT) && ((s_ff.bit_cnt < CMD_LAST)
                || (s_ff.bit_cnt == CMD_LAST && (!s_ff.sk_ph || s_ff.half_cnt == 8'd0))); // RL15
        end else if (sw_on) begin
            nxt_s.pins.cs = s_ff.prom_ctl[PCT_CS_BIT]; // RL10 RL13
            nxt_s.pins.sk = s_ff.prom_ctl[PCT_SK_BIT]; // RL13
            nxt_s.pins.do_o = s_ff.prom_ctl[PCT_DO_BIT]; // RL13
            nxt_s.pins.do_oe = s_ff.prom_ctl[PCT_DIR_BIT]; // RL11
        end else begin
            nxt_s.pins = '0;
        end
        nxt_s.irq = |(nxt_s.irq_stat & nxt_s.irq_mask);
        nxt_s.drive_16ma = nxt_s.bus_clk[BCC_DRIVE_BIT]; // RL8
        // Source 1 and divider 11 are reserved: hold undivided
        if (nxt_s.bus_clk[BCC_SRC_BIT] || nxt_s.bus_clk[1:0] == BCC_DIV_RSVD) begin
            nxt_s.div_sel = 2'h0; // RL6 RL7
        end else begin
            nxt_s.div_sel = nxt_s.bus_clk[1:0]; // RL7
        end
    end

    //----------------------------------------
    // State register
    //----------------------------------------
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            s_ff <= '0;
            s_ff.ld <= LD_IDLE;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign reg_rdata_o = s_ff.rdata;
    assign irq_o = s_ff.irq;
    assign prom_data_pin_o = s_ff.pins.do_o;
    assign prom_data_pin_oe_o = s_ff.pins.do_oe;
    assign prom_serial_clock_pin_o = s_ff.pins.sk;
    assign prom_chip_select_pin_o = s_ff.pins.cs;
    assign drive_16ma_o = s_ff.drive_16ma;
    assign bus_clk_div_o = s_ff.div_sel;

    //----------------------------------------
    // Checks
    //----------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);

    //----------------------------------------
    // Loader checks
    //----------------------------------------
    load_only_present_a: assert property (s_ff.ld == LD_STORE |-> s_ff.present) // RL5
        else $error("loader ran without prom");

    no_load_absent_a: assert property ( // RL5
        s_ff.strap_taken && !s_ff.present |-> s_ff.ld == LD_DONE)
        else $error("loader left idle with no prom");

    load_command_a: assert property ( // RL1 RL2
        s_ff.ld == LD_SHIFT && s_ff.bit_cnt == 5'd0 |-> s_ff.shreg[26:24] == PROM_READ_OP
        && s_ff.shreg[23:16] == PROM_FIRST_WORD + 8'(s_ff.word_idx))
        else $error("wrong prom command");

    load_low_word_a: assert property ( // RL1 RL2
        s_ff.ld == LD_STORE && s_ff.word_idx == 2'd0 && !req.wr
        |=> s_ff.mac_low == $past(s_ff.shreg[15:0]))
        else $error("low word not loaded");

    load_mid_word_a: assert property ( // RL2
        s_ff.ld == LD_STORE && s_ff.word_idx == 2'd1 && !req.wr
        |=> s_ff.mac_mid == $past(s_ff.shreg[15:0]))
        else $error("mid word not loaded");

    load_high_word_a: assert property ( // RL2
        s_ff.ld == LD_STORE && s_ff.word_idx == 2'd2 && !req.wr
        |=> s_ff.mac_high == $past(s_ff.shreg[15:0]) && s_ff.ld == LD_DONE)
        else $error("high word not loaded");

    load_irq_a: assert property (load_evt |=> s_ff.irq_stat[IRQ_LOAD_BIT]) // RL1
        else $error("load done not flagged");

    loader_owns_a: assert property (s_ff.ld == LD_SHIFT |=> prom_chip_select_pin_o) // RL15
        else $error("loader lost pins");

    loader_release_a: assert property ( // RL15
        s_ff.ld == LD_SHIFT && s_ff.bit_cnt > CMD_LAST |=> !prom_data_pin_oe_o)
        else $error("loader drives data phase");

    //----------------------------------------
    // Register checks
    //----------------------------------------
    mac_write_a: assert property ( // RL3
        req.wr && req.addr == ADDR_MAC_MID && s_ff.ld != LD_STORE
        |=> s_ff.mac_mid == $past(req.wdata))
        else $error("mid word write lost");

    low_write_a: assert property ( // RL3
        req.wr && req.addr == ADDR_MAC_LOW && s_ff.ld != LD_STORE
        |=> s_ff.mac_low == $past(req.wdata))
        else $error("low word write lost");

    high_write_a: assert property ( // RL3
        req.wr && req.addr == ADDR_MAC_HIGH && s_ff.ld != LD_STORE
        |=> s_ff.mac_high == $past(req.wdata))
        else $error("high word write lost");

    mac_read_a: assert property ( // RL3
        req.rd && req.addr == ADDR_MAC_HIGH |=> reg_rdata_o == $past(s_ff.mac_high))
        else $error("high word read wrong");

    rdata_idle_a: assert property (!req.rd |=> reg_rdata_o == RESET_ZERO16) // RL3
        else $error("read data not cleared");

    cfg_read_a: assert property ( // RL19
        req.rd && req.addr == ADDR_CHIP_CFG
        |=> reg_rdata_o[CCR_PRESENT_BIT] == $past(s_ff.present))
        else $error("presence read wrong");

    presence_a: assert property (s_ff.strap_taken |=> $stable(s_ff.present)) // RL19
        else $error("presence flag changed");

    drive_sel_a: assert property ( // RL8
        req.wr && req.addr == ADDR_BUS_CLK |=> drive_16ma_o == $past(req.wdata[BCC_DRIVE_BIT]))
        else $error("drive strength not applied");

    div_rsvd_a: assert property ( // RL7
        s_ff.bus_clk[1:0] == BCC_DIV_RSVD |-> bus_clk_div_o == 2'h0)
        else $error("reserved divider passed");

    src_rsvd_a: assert property (s_ff.bus_clk[BCC_SRC_BIT] |-> bus_clk_div_o == 2'h0) // RL6
        else $error("reserved source passed");

    div_pass_a: assert property ( // RL7
        !s_ff.bus_clk[BCC_SRC_BIT] && s_ff.bus_clk[1:0] != BCC_DIV_RSVD
        |-> bus_clk_div_o == s_ff.bus_clk[1:0])
        else $error("divider not applied");

    bus_clk_read_a: assert property ( // RL6 RL7 RL8
        req.rd && req.addr == ADDR_BUS_CLK |=> reg_rdata_o == $past(s_ff.bus_clk))
        else $error("bus control read wrong");

    //----------------------------------------
    // Pin checks
    //----------------------------------------
    sw_pins_a: assert property ( // RL13
        sw_on |=> prom_chip_select_pin_o == $past(s_ff.prom_ctl[PCT_CS_BIT])
        && prom_serial_clock_pin_o == $past(s_ff.prom_ctl[PCT_SK_BIT]))
        else $error("software pins wrong");

    sw_dir_a: assert property ( // RL11 RL13
        sw_on |=> prom_data_pin_oe_o == $past(s_ff.prom_ctl[PCT_DIR_BIT])
        && prom_data_pin_o == $past(s_ff.prom_ctl[PCT_DO_BIT]))
        else $error("software data pin wrong");

    sw_off_a: assert property ( // RL10
        !ld_busy && !sw_on |=> !prom_chip_select_pin_o && !prom_serial_clock_pin_o
        && !prom_data_pin_oe_o)
        else $error("pins driven without owner");

    din_read_a: assert property ( // RL12
        req.rd && req.addr == ADDR_PROM_CTL |=> reg_rdata_o[3] == $past(s_ff.din_s2))
        else $error("data pin read wrong");

    wo_bit_a: assert property ( // RL11
        req.rd && req.addr == ADDR_PROM_CTL |=> !reg_rdata_o[PCT_DIR_BIT])
        else $error("direction bit readable");

    //----------------------------------------
    // Self test checks and coverage
    //----------------------------------------
    bist_done_a: assert property ( // RL16 RL17 RL18
        $rose(s_ff.bist[12]) |-> s_ff.bist[4] && s_ff.bist_cnt == 7'(BIST_CYCLES))
        else $error("self test report wrong");

    bist_tx_a: assert property ( // RL17
        $rose(s_ff.bist[12]) |-> s_ff.bist[11] == $past(tx_selftest_failed_i)
        && s_ff.bist[10:8] == $past(tx_selftest_fail_count_i))
        else $error("tx test result wrong");

    bist_rx_a: assert property ( // RL18
        $rose(s_ff.bist[4]) |-> s_ff.bist[3] == $past(rx_selftest_failed_i)
        && s_ff.bist[2:0] == $past(rx_selftest_fail_count_i))
        else $error("rx test result wrong");

    bist_hold_a: assert property (s_ff.bist[12] |=> $stable(s_ff.bist)) // RL16 RL17
        else $error("self test report changed");

    bist_rsvd_a: assert property ( // RL18
        req.rd && req.addr == ADDR_BIST
        |=> reg_rdata_o[15:13] == 3'h0 && reg_rdata_o[7:5] == 3'h0)
        else $error("reserved report bits set");

    load_cov_c: cover property (load_evt);
    sw_cov_c: cover property (sw_on && prom_data_pin_oe_o);
    irq_cov_c: cover property ($rose(irq_o));
    bist_cov_c: cover property (bist_evt);
    absent_cov_c: cover property (s_ff.strap_taken && !s_ff.present);

endmodule // hcer_regs

//--- core/hcer_pkg.sv
package hcer_pkg;
    // Register offsets (byte addresses)
    localparam logic [7:0] ADDR_CHIP_CFG = 8'h08;
    localparam logic [7:0] ADDR_MAC_LOW = 8'h10;
    localparam logic [7:0] ADDR_MAC_MID = 8'h12;
    localparam logic [7:0] ADDR_MAC_HIGH = 8'h14;
    localparam logic [7:0] ADDR_BUS_CLK = 8'h20;
    localparam logic [7:0] ADDR_PROM_CTL = 8'h22;
    localparam logic [7:0] ADDR_BIST = 8'h24;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h40;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h42;
    // Field positions
    localparam int BCC_DRIVE_BIT = 6;
    localparam int BCC_SRC_BIT = 2;
    localparam int PCT_DIR_BIT = 5;
    localparam int PCT_EN_BIT = 4;
    localparam int PCT_DIN_BIT = 3;
    localparam int PCT_DO_BIT = 2;
    localparam int PCT_SK_BIT = 1;
    localparam int PCT_CS_BIT = 0;
    localparam int CCR_PRESENT_BIT = 9;
    localparam int IRQ_LOAD_BIT = 0;
    localparam int IRQ_BIST_BIT = 1;
    localparam logic [15:0] BCC_WR_MASK = 16'hffff;
    localparam logic [15:0] RESET_ZERO16 = 16'h0000;
    localparam logic [1:0] BCC_DIV_RSVD = 2'h3;
    // Loader: first prom word, read opcode, timing
    localparam logic [7:0] PROM_FIRST_WORD = 8'h01;
    localparam logic [2:0] PROM_READ_OP = 3'h6;
    localparam int CLK_MHZ = 50;
    localparam int PROM_SK_HALF_NS = 1000;
    localparam int PROM_SK_HALF_CYC = (PROM_SK_HALF_NS * CLK_MHZ + 999) / 1000;
    localparam int BIST_CYCLES = 64;
    localparam logic [4:0] SHIFT_LAST = 5'd26;
    localparam logic [4:0] CMD_LAST = 5'd10;
    localparam logic [4:0] STRAP_WAIT = 5'd2;

    typedef enum logic [2:0] {
        LD_IDLE = 3'b000,
        LD_CSUP = 3'b001,
        LD_SHIFT = 3'b011,
        LD_STORE = 3'b010,
        LD_DONE = 3'b110
    } hcer_ld_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } hcer_bus_req_t;

    typedef struct packed {
        logic do_o;
        logic do_oe;
        logic sk;
        logic cs;
    } hcer_prom_pins_t;

    typedef struct packed {
        logic [15:0] mac_low;
        logic [15:0] mac_mid;
        logic [15:0] mac_high;
        logic [15:0] bus_clk;
        logic [5:0] prom_ctl;
        logic [15:0] bist;
        logic present;
        logic strap_taken;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        hcer_ld_t ld;
        logic [1:0] word_idx;
        logic [4:0] bit_cnt;
        logic [7:0] half_cnt;
        logic sk_ph;
        logic [26:0] shreg;
        logic [15:0] rdata;
        logic [6:0] bist_cnt;
        hcer_prom_pins_t pins;
        logic irq;
        logic drive_16ma;
        logic [1:0] div_sel;
        logic din_s1;
        logic din_s2;
    } hcer_state_t;
endpackage

//--- tb/hcer_prom_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Serial prom, read command, x16 words
// ----------------------------------------
module hcer_prom_model (
    // Prom pins
    input wire logic cs_i,
    input wire logic sk_i,
    input wire logic di_i,
    output logic do_o,
    output logic do_en_o
);
    logic [15:0] mem [256];
    logic [10:0] cmd = 11'h000;
    logic [16:0] sh = 17'h00000;
    int n_bits = 0;
    int n_sel = 0;

    initial do_en_o = 1'b0;
    always @(posedge cs_i) n_sel = n_sel + 1;
    always @(negedge cs_i) begin
        n_bits = 0;
        do_en_o = 1'b0;
    end
    // Start, opcode, address in; dummy zero then data out MSB first
    always @(posedge sk_i) begin
        if (cs_i === 1'b1) begin
            n_bits = n_bits + 1;
            if (n_bits <= 11) cmd = {cmd[9:0], di_i};
            if (n_bits == 11 && cmd[10:8] == 3'h6) begin
                sh = {1'b0, mem[cmd[7:0]]};
                do_en_o = 1'b1;
            end else if (n_bits > 11) begin
                sh = {sh[15:0], 1'b0};
            end
            if (n_bits > 27) do_en_o = 1'b0;
        end
    end
    assign do_o = sh[16];
endmodule // hcer_prom_model

//--- tb/hcer_regs_bench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module hcer_regs_bench;
    import hcer_pkg::*;
    logic mclk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] reg_addr_i = 8'h00;
    logic [15:0] reg_wdata_i = 16'h0000;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [15:0] reg_rdata_o;
    logic irq_o, pin_o, pin_oe, sk, cs, drv16, prom_do, prom_en, pin;
    logic [1:0] div;
    logic tx_f = 1'b0;
    logic rx_f = 1'b0;
    logic [2:0] tx_c = 3'h0;
    logic [2:0] rx_c = 3'h0;
    logic pull_lvl = 1'b1;
    int n_errors = 0;
    int num_checks = 0;

    always #10 mclk_i = ~mclk_i;
    // Wire level: device, then prom, else board pull
    assign pin = pin_oe ? pin_o : (prom_en ? prom_do : pull_lvl);

    hcer_regs dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .irq_o(irq_o), .tx_selftest_failed_i(tx_f),
        .tx_selftest_fail_count_i(tx_c), .rx_selftest_failed_i(rx_f),
        .rx_selftest_fail_count_i(rx_c), .prom_data_pin_i(pin), .prom_data_pin_o(pin_o),
        .prom_data_pin_oe_o(pin_oe), .prom_serial_clock_pin_o(sk),
        .prom_chip_select_pin_o(cs), .drive_16ma_o(drv16), .bus_clk_div_o(div));
    hcer_prom_model prom (.cs_i(cs), .sk_i(sk), .di_i(pin), .do_o(prom_do), .do_en_o(prom_en));

    // ----------------------------------------
    // Bus tasks and run control
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge mclk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge mclk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge mclk_i);
        reg_rd_i <= 1'b0;
        #1;
        d = reg_rdata_o;
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
        logic [15:0] d;
        rd(a, d);
        `CHK(d & m, e)
    endtask
    task automatic do_reset();
        @(posedge mclk_i);
        sys_rst_i <= 1'b1;
        repeat (12) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic [15:0] d, v;
        logic [15:0] mac_m [3];
        int i, sel0;
        void'($urandom(36));
        {tx_f, tx_c, rx_f, rx_c} <= 8'($urandom);
        for (i = 0; i < 3; i++) begin
            mac_m[i] = 16'($urandom);
            prom.mem[i + 1] = mac_m[i];
        end
        repeat (12) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        chk_rd(ADDR_BUS_CLK, 16'h0047, 16'h0000);
        chk_rd(ADDR_PROM_CTL, 16'h0037, 16'h0000);
        chk_rd(ADDR_CHIP_CFG, 16'h0200, 16'h0200);
        wr(ADDR_PROM_CTL, 16'h0010);
        d = 16'h0000;
        for (i = 0; i < 5000 && d[0] !== 1'b1; i++) rd(ADDR_IRQ_STAT, d);
        if (d[0] !== 1'b1) begin
            n_errors++;
            end_sim();
        end
        for (i = 0; i < 3; i++) chk_rd(ADDR_MAC_LOW + 8'(2 * i), 16'hffff, mac_m[i]);
        chk_rd(ADDR_BIST, 16'hffff, {3'h0, 1'b1, tx_f, tx_c, 3'h0, 1'b1, rx_f, rx_c});
        // Interrupt: raise, mask, clear
        chk_rd(ADDR_IRQ_STAT, 16'h0003, 16'h0003);
        `CHK(irq_o, 1'b0)
        wr(ADDR_IRQ_MASK, 16'h0001);
        repeat (2) @(posedge mclk_i);
        `CHK(irq_o, 1'b1)
        wr(ADDR_IRQ_STAT, 16'h0001);
        repeat (2) @(posedge mclk_i);
        `CHK(irq_o, 1'b0)
        chk_rd(ADDR_IRQ_STAT, 16'h0003, 16'h0002);
        wr(ADDR_IRQ_MASK, 16'h0003);
        repeat (2) @(posedge mclk_i);
        `CHK(irq_o, 1'b1)
        wr(ADDR_IRQ_STAT, 16'h0002);
        repeat (2) @(posedge mclk_i);
        `CHK(irq_o, 1'b0)
        // Bus clock control: every divider code and the source bit
        for (i = 0; i < 5; i++) begin
            v = {16'($urandom) & 16'hfff8} | 16'(i[1:0]) | (i == 4 ? 16'h0004 : 16'h0000);
            wr(ADDR_BUS_CLK, v);
            chk_rd(ADDR_BUS_CLK, 16'hffff, v);
            `CHK(drv16, v[6])
            `CHK(div, (v[2] || v[1:0] == 2'h3) ? 2'h0 : v[1:0])
        end
        wr(ADDR_BUS_CLK, 16'h0000);
        // Software pin access, both directions and both pull levels
        for (i = 0; i < 8; i++) begin
            d = 16'($urandom);
            pull_lvl <= d[4];
            v = {10'h000, d[3], 1'b1, 1'b0, d[2:0]};
            wr(ADDR_PROM_CTL, v);
            repeat (4) @(posedge mclk_i);
            `CHK({cs, sk, pin_oe}, {v[0], v[1], v[5]})
            if (v[5]) `CHK(pin_o, v[2])
            chk_rd(ADDR_PROM_CTL, 16'h003f, {11'h000, 1'b1, v[5] ? v[2] : d[4], v[2:0]});
        end
        pull_lvl <= 1'b1;
        wr(ADDR_PROM_CTL, 16'h0027);
        repeat (2) @(posedge mclk_i);
        `CHK({cs, sk, pin_oe}, 3'h0)
        chk_rd(8'h30, 16'hffff, 16'h0000);
        // Second reset without a prom fitted
        pull_lvl <= 1'b0;
        sel0 = prom.n_sel;
        do_reset();
        repeat (300) @(posedge mclk_i);
        chk_rd(ADDR_CHIP_CFG, 16'h0200, 16'h0000);
        chk_rd(ADDR_IRQ_STAT, 16'h0001, 16'h0000);
        for (i = 0; i < 3; i++) begin
            mac_m[i] = 16'($urandom);
            wr(ADDR_MAC_LOW + 8'(2 * i), mac_m[i]);
        end
        for (i = 0; i < 3; i++) chk_rd(ADDR_MAC_LOW + 8'(2 * i), 16'hffff, mac_m[i]);
        `CHK(prom.n_sel, sel0)
        end_sim();
    end
endmodule // hcer_regs_bench
